// ===== design/dmc_regs.svh
// Timing counts and address layout for the dynamic memory cycle controller.
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH

// ---------------------------------------------------------------------------
// Clock and timing figures
// ---------------------------------------------------------------------------
// Clock period in ns.
`define DMC_CLK_NS          10
// Least times in ns (fast grade), and their cycle counts rounded up.
`define DMC_RAS_MIN_NS      150
`define DMC_RAS_MIN_CYC     ((`DMC_RAS_MIN_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_PRE_MIN_NS      120
`define DMC_PRE_MIN_CYC     ((`DMC_PRE_MIN_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_RCD_MIN_NS      30
`define DMC_RCD_MIN_CYC     ((`DMC_RCD_MIN_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_CAS_MIN_NS      75
`define DMC_CAS_MIN_CYC     ((`DMC_CAS_MIN_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_CYC_MIN_NS      300
`define DMC_CYC_MIN_CYC     ((`DMC_CYC_MIN_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
// Refresh period 2 ms in ns, over 128 rows, rounded down per row.
`define DMC_REF_PERIOD_NS   2000000
`define DMC_REF_ROWS        128
`define DMC_REF_INT_CYC     (`DMC_REF_PERIOD_NS / `DMC_REF_ROWS / `DMC_CLK_NS)
// Power-up pause 100 us in ns, rounded up, and the wake-up strobe count.
`define DMC_PWRUP_NS        100000
`define DMC_PWRUP_CYC       ((`DMC_PWRUP_NS + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_WAKE_CYCLES     8

// ---------------------------------------------------------------------------
// Address layout
// ---------------------------------------------------------------------------
`define DMC_ADDR_W          15
`define DMC_PIN_W           8
`define DMC_REF_ROW_W       7

`endif

// ===== design/dmc_pkg.sv
// Types shared by the dynamic memory cycle controller.
package dmc_pkg;

	// Kind of access a request asks for.
	typedef enum logic [1:0]
	{
		DMC_OP_READ,
		DMC_OP_WRITE,
		DMC_OP_RMW
	} dmc_op_type;

	// Controller sequence states.
	typedef enum logic [3:0]
	{
		DMC_ST_PWRUP,
		DMC_ST_IDLE,
		DMC_ST_ROW,
		DMC_ST_COL,
		DMC_ST_RMW_WR,
		DMC_ST_HOLD,
		DMC_ST_PRE
	} dmc_state_type;

endpackage

// ===== design/dmc_ctrl.sv
// Host controller that runs read, write, read-modify-write and refresh cycles on a 32K x 1 dynamic RAM.
`timescale 1ns/100ps

`include "dmc_regs.svh"

module dmc_ctrl
#(
	parameter int PWRUP_CYC   = `DMC_PWRUP_CYC,
	parameter int REF_INT_CYC = `DMC_REF_INT_CYC,
	parameter bit HALF_SEL    = 1'b0
)
(
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     nrst,
	// User request side.
	input  wire logic                     req_valid,
	input  wire dmc_pkg::dmc_op_type      req_op,
	input  wire logic [`DMC_ADDR_W-1:0]   req_addr,
	input  wire logic                     req_wdata,
	output logic                          req_ready,
	output logic                          rsp_valid,
	output logic                          rsp_rdata,
	output logic                          init_done,
	// Memory pins.
	output logic [`DMC_PIN_W-1:0]         mem_addr,
	output logic                          row_strobe_n,
	output logic                          column_strobe_n,
	output logic                          write_strobe_n,
	output logic                          mem_din,
	input  wire logic                     mem_dout
);

	// ------------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------------
	// The sequencer counts need room for at least one full cycle between refreshes.
	if (REF_INT_CYC < `DMC_CYC_MIN_CYC + 2)
		$error("REF_INT_CYC too small for one access cycle");
	if (PWRUP_CYC < 1)
		$error("PWRUP_CYC must be at least one");
	localparam int CW = 20;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	dmc_pkg::dmc_state_type state_q;           // Sequencer state.
	logic [CW-1:0]          tmr_q;             // Cycles spent in present state.
	logic [CW-1:0]          cyc_q;             // Cycles since row strobe fell.
	logic [CW-1:0]          ref_tmr_q;         // Refresh interval timer.
	logic                   ref_due_q;         // A refresh row is owed.
	logic [`DMC_REF_ROW_W-1:0] ref_row_q;      // Next row to refresh.
	logic [3:0]             wake_q;            // Wake-up strobe cycles done.
	logic                   is_ref_q;          // Present cycle is a refresh.
	dmc_pkg::dmc_op_type    op_q;              // Latched operation.
	logic [`DMC_ADDR_W-1:0] addr_q;            // Latched address.
	logic                   wdata_q;           // Latched write bit.
	logic                   dout_s1_q;         // Data pin synchroniser, first stage.
	logic                   dout_s2_q;         // Data pin synchroniser, second stage.

	// ------------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------------
	// Row phase takes the low eight bits; the column phase the upper seven under the half select.
	// address split
	wire [`DMC_PIN_W-1:0] row_pins = req_addr[7:0];
	wire [`DMC_PIN_W-1:0] col_pins = {HALF_SEL, addr_q[14:8]};
	wire [`DMC_PIN_W-1:0] ref_pins = {1'b0, ref_row_q};
	wire tmr_ras   = tmr_q >= CW'(`DMC_RCD_MIN_CYC - 1);
	wire tmr_cas   = tmr_q >= CW'(`DMC_CAS_MIN_CYC + 2);
	wire cyc_ras   = cyc_q >= CW'(`DMC_RAS_MIN_CYC - 1);
	wire tmr_pre   = tmr_q >= CW'(`DMC_PRE_MIN_CYC - 1);
	wire ref_tick  = ref_tmr_q >= CW'(REF_INT_CYC - 1);
	wire pwr_over  = tmr_q >= CW'(PWRUP_CYC - 1);
	wire start_ok  = (state_q == dmc_pkg::DMC_ST_IDLE);
	wire take_ref  = start_ok && ref_due_q;
	wire take_req  = start_ok && !ref_due_q && req_valid;
	wire start_ref = start_ok && (!init_done || ref_due_q);  // Next cycle is row-only.
	wire start_row = start_ref || take_req;                  // Any cycle starts now.

	// ------------------------------------------------------------------------
	// Refresh interval timer
	// ------------------------------------------------------------------------
	// A pending refresh stays owed until taken; a new tick while owed is
	// merged, which only happens if REF_INT_CYC is shorter than a read-modify-write cycle.
	// refresh interval
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			{ref_tmr_q, ref_due_q} <= '0;
		else
		begin
			ref_tmr_q <= ref_tick ? '0 : ref_tmr_q + 1'b1;
			// Set wins over the clear when both land in one cycle.
			ref_due_q <= (ref_tick && init_done) | (ref_due_q & ~take_ref);
		end
	end

	// ------------------------------------------------------------------------
	// Data pin synchroniser
	// ------------------------------------------------------------------------
	// The device output is asynchronous to our clock.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			{dout_s2_q, dout_s1_q} <= 2'h0;
		else
			{dout_s2_q, dout_s1_q} <= {dout_s1_q, mem_dout};
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	// Each access cycle: row strobe, column strobe after the lead time, hold for the
	// access, release, then precharge until the least cycle time has run.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q         <= dmc_pkg::DMC_ST_PWRUP;
			tmr_q           <= '0;
			cyc_q           <= '0;
			ref_row_q       <= '0;
			wake_q          <= '0;
			is_ref_q        <= 1'b0;
			op_q            <= dmc_pkg::DMC_OP_READ;
			addr_q          <= '0;
			wdata_q         <= 1'b0;
			init_done       <= 1'b0;
			req_ready       <= 1'b0;
			rsp_valid       <= 1'b0;
			rsp_rdata       <= 1'b0;
			mem_addr        <= '0;
			row_strobe_n    <= 1'b1;
			column_strobe_n <= 1'b1;
			write_strobe_n  <= 1'b1;
			mem_din         <= 1'b0;
		end
		else
		begin
			tmr_q     <= tmr_q + 1'b1;
			cyc_q     <= cyc_q + 1'b1;
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			unique case (state_q)
				dmc_pkg::DMC_ST_PWRUP:
				begin
					if (pwr_over)
					begin
						state_q <= dmc_pkg::DMC_ST_IDLE;
						tmr_q   <= '0;
					end
				end
				dmc_pkg::DMC_ST_IDLE:
				begin
					// Wake-up cycles and refreshes are row-only cycles.
					// eight wake cycles
					if (start_row)
					begin
						is_ref_q     <= start_ref;
						req_ready    <= !start_ref;
						op_q         <= req_op;
						addr_q       <= req_addr;
						wdata_q      <= req_wdata;
						mem_addr     <= start_ref ? ref_pins : row_pins;
						row_strobe_n <= 1'b0;
						state_q      <= dmc_pkg::DMC_ST_ROW;
						tmr_q        <= '0;
						cyc_q        <= '0;
					end
				end
				dmc_pkg::DMC_ST_ROW:
				begin
					if (is_ref_q && cyc_ras)
					begin
						row_strobe_n <= 1'b1;
						state_q      <= dmc_pkg::DMC_ST_PRE;
						tmr_q        <= '0;
					end
					else if (!is_ref_q && tmr_ras)
					begin
						mem_addr        <= col_pins;
						column_strobe_n <= 1'b0;
						write_strobe_n  <= (op_q != dmc_pkg::DMC_OP_WRITE);
						mem_din         <= wdata_q;
						state_q         <= dmc_pkg::DMC_ST_COL;
						tmr_q           <= '0;
					end
				end
				dmc_pkg::DMC_ST_COL:
				begin
					if (tmr_cas && cyc_ras)
					begin
						if (op_q == dmc_pkg::DMC_OP_RMW)
						begin
							rsp_rdata      <= dout_s2_q;
							mem_din        <= wdata_q;
							write_strobe_n <= 1'b0;
							state_q        <= dmc_pkg::DMC_ST_RMW_WR;
						end
						else
						begin
							rsp_rdata <= dout_s2_q;
							rsp_valid <= 1'b1;
							state_q   <= dmc_pkg::DMC_ST_HOLD;
						end
						tmr_q <= '0;
					end
				end
				dmc_pkg::DMC_ST_RMW_WR:
				begin
					if (tmr_q >= CW'(`DMC_CAS_MIN_CYC - 1))
					begin
						rsp_valid <= 1'b1;
						state_q   <= dmc_pkg::DMC_ST_HOLD;
						tmr_q     <= '0;
					end
				end
				dmc_pkg::DMC_ST_HOLD:
				begin
					// Both strobes rise together; write rises one cycle later.
					// row strobe width
					row_strobe_n    <= 1'b1;
					column_strobe_n <= 1'b1;
					state_q         <= dmc_pkg::DMC_ST_PRE;
					tmr_q           <= '0;
				end
				dmc_pkg::DMC_ST_PRE:
				begin
					write_strobe_n <= 1'b1;
					if (tmr_pre && cyc_q >= CW'(`DMC_CYC_MIN_CYC - 1))
					begin
						state_q <= dmc_pkg::DMC_ST_IDLE;
						if (is_ref_q)
						begin
							ref_row_q <= ref_row_q + 1'b1;
							if (!init_done)
							begin
								wake_q    <= wake_q + 1'b1;
								init_done <= (wake_q == 4'(`DMC_WAKE_CYCLES - 1));
							end
						end
					end
				end
				default:
				begin
					state_q <= dmc_pkg::DMC_ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ===== testbench/dmc_ctrl_monitor.sv
// Port-level assertions for the dynamic memory cycle controller.
`timescale 1ns/100ps
module dmc_ctrl_monitor
#(
	parameter bit HALF = 1'b0
)
(
	// Clock and reset.
	input wire logic                clk,
	input wire logic                nrst,
	// Request side.
	input wire dmc_pkg::dmc_op_type req_op,
	input wire logic                req_ready,
	input wire logic                rsp_valid,
	input wire logic                init_done,
	// Memory strobes.
	input wire logic                row_strobe_n,
	input wire logic                column_strobe_n,
	input wire logic                write_strobe_n,
	input wire logic [7:0]          mem_addr
);
	// -------------------------------------------------------------------
	// Strobe cycle counters
	// -------------------------------------------------------------------
	logic [15:0] row_lo_q; // Cycles the row strobe has been low.
	logic [15:0] row_hi_q; // Cycles the row strobe has been high.
	logic [15:0] col_lo_q; // Cycles the column strobe has been low.
	logic [15:0] since_q;  // Cycles since the last row strobe fall.
	// Counters restart on each strobe edge; 16 bits cover the 10 us ceiling.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			row_lo_q <= 16'h0000;
			row_hi_q <= 16'h0000;
			col_lo_q <= 16'h0000;
			since_q  <= 16'h00FF;
		end
		else
		begin
			row_lo_q <= row_strobe_n ? 16'h0000 : row_lo_q + 16'h0001;
			row_hi_q <= row_strobe_n ? row_hi_q + 16'h0001 : 16'h0000;
			col_lo_q <= column_strobe_n ? 16'h0000 : col_lo_q + 16'h0001;
			since_q  <= (!row_strobe_n && row_hi_q != 16'h0000) ? 16'h0001 : since_q + 16'h0001;
		end
	end
	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_ready_row: assert property (req_ready |-> $fell(row_strobe_n))
		else $error("Row strobe did not fall with ready.");
	chk_col_delay: assert property (req_ready |-> ##3 $fell(column_strobe_n))
		else $error("Column strobe not three cycles after row.");
	chk_rw_answer: assert property (req_ready && req_op != dmc_pkg::DMC_OP_RMW |-> ##15 rsp_valid)
		else $error("Read or write answer late.");
	chk_rmw_answer: assert property (req_ready && req_op == dmc_pkg::DMC_OP_RMW |-> ##23 rsp_valid)
		else $error("Read-modify-write answer late.");
	chk_row_width: assert property ($rose(row_strobe_n) |-> row_lo_q >= 16'd15 && row_lo_q <= 16'd1000)
		else $error("Row strobe width out of range.");
	chk_precharge_time: assert property ($fell(row_strobe_n) |-> row_hi_q >= 16'd12)
		else $error("Row precharge too short.");
	chk_cycle_space: assert property ($fell(row_strobe_n) |-> since_q >= 16'd30)
		else $error("Row cycles too close.");
	chk_col_width: assert property ($rose(column_strobe_n) |-> col_lo_q >= 16'd8 && col_lo_q <= 16'd1000)
		else $error("Column strobe width out of range.");
	chk_write_in_col: assert property ($fell(write_strobe_n) |-> !column_strobe_n)
		else $error("Write strobe fell outside column phase.");
	chk_wake_quiet: assert property (!init_done |-> column_strobe_n && write_strobe_n)
		else $error("Column or write strobe active before init.");
	chk_half_select: assert property ($fell(column_strobe_n) |-> mem_addr[7] == HALF)
		else $error("Column phase top pin is not the half select.");
endmodule

// ===== testbench/dmc_dram_model.sv
// Behavioural model of the 32K x 1 dynamic RAM on the controller's pins.
`timescale 1ns/100ps
module dmc_dram_model
#(
	parameter bit HALF = 1'b0
)
(
	// Memory pins.
	input  wire logic [7:0] mem_addr,
	input  wire logic       row_strobe_n,
	input  wire logic       column_strobe_n,
	input  wire logic       write_strobe_n,
	input  wire logic       mem_din,
	output logic            mem_dout,
	// Observation for the bench.
	output int              viol,
	output int              wake,
	output logic [127:0]    refreshed
);
	logic       mem [0:32767];
	logic [7:0] row_q;             // Latched row address.
	logic [7:0] col_q;             // Latched column address.
	logic       col_seen = 1'b1;   // Column phase seen in this row cycle.
	realtime    t_rf = -1000.0;    // Last row fall.
	realtime    t_rr = -1000.0;    // Last row rise.
	realtime    t_cf = -1000.0;    // Last column fall.
	initial
	begin
		viol = 0;
		wake = 0;
		refreshed = '0;
		mem_dout = 1'b0;
	end
	always @(negedge row_strobe_n)
	begin
		if ($realtime - t_rr < 120.0 || $realtime - t_rf < 300.0)
			viol++;
		t_rf = $realtime;
		col_seen = 1'b0;
		#1 row_q = mem_addr;
	end
	always @(posedge row_strobe_n)
	begin
		if ($realtime > 0.0)
		begin
			if ($realtime - t_rf < 150.0 || $realtime - t_rf > 10000.0)
				viol++;
			t_rr = $realtime;
			if (!col_seen)
			begin
				refreshed[row_q[6:0]] = 1'b1;
				wake++;
			end
		end
	end
	always @(negedge column_strobe_n)
	begin
		t_cf = $realtime;
		if (t_cf - t_rf < 30.0)
			viol++;
		// The released line shows the inverse, so a stale value never passes.
		mem_dout = ~mem_dout;
		#1 col_q = mem_addr;
		col_seen = 1'b1;
		if (col_q[7] == HALF && !write_strobe_n)
			mem[{row_q, col_q[6:0]}] = mem_din;
		else if (col_q[7] == HALF)
		begin
			#74 if (!column_strobe_n) mem_dout = mem[{row_q, col_q[6:0]}];
		end
	end
	always @(negedge write_strobe_n)
	begin
		#1 if (col_seen && !column_strobe_n && $realtime - t_cf >= 45.0 && col_q[7] == HALF)
			mem[{row_q, col_q[6:0]}] = mem_din;
	end
	always @(posedge column_strobe_n)
	begin
		if ($realtime - t_cf < 75.0)
			viol++;
		mem_dout = ~mem_dout;
	end
endmodule

// ===== testbench/dmc_ctrl_tb_top.sv
// Self-checking testbench top for the dynamic memory cycle controller.
`timescale 1ns/100ps
module dmc_ctrl_tb_top;
	logic                clk = 1'b0;
	logic                nrst = 1'b0;
	logic                req_valid = 1'b0;
	dmc_pkg::dmc_op_type req_op = dmc_pkg::DMC_OP_READ;
	logic [14:0]         req_addr = 15'h0000;
	logic                req_wdata = 1'b0;
	logic                req_ready, rsp_valid, rsp_rdata, init_done, mem_din, mem_dout;
	logic                row_strobe_n, column_strobe_n, write_strobe_n, rd;
	logic [7:0]          mem_addr;
	logic [127:0]        refreshed;
	int                  viol, wake;
	int                  fails = 0;
	int                  samples_checked = 0;
	always #5 clk = ~clk;
	// Short power-up pause keeps the run brief.
	dmc_ctrl #(.PWRUP_CYC(20), .REF_INT_CYC(200)) uut (.clk, .nrst, .req_valid, .req_op, .req_addr,
		.req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .init_done, .mem_addr, .row_strobe_n,
		.column_strobe_n, .write_strobe_n, .mem_din, .mem_dout);
	dmc_dram_model model (.mem_addr, .row_strobe_n, .column_strobe_n, .write_strobe_n, .mem_din,
		.mem_dout, .viol, .wake, .refreshed);
	// -------------------------------------------------------------------
	// Compare tasks
	// -------------------------------------------------------------------
	task automatic chk_bit(input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int exp, input int got);
		samples_checked++;
		if (got != exp)
		begin
			fails++;
			$display("Error at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask
	// Holds the request until ready is sampled, then waits for the answer.
	task automatic access(input dmc_pkg::dmc_op_type op, input logic [14:0] a, input logic d);
		int n;
		req_op = op;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		for (n = 0; n < 2000 && req_ready !== 1'b1; n++) @(posedge clk) #1;
		// Ready stands until the next edge; release only after that edge.
		@(posedge clk) #1 req_valid = 1'b0;
		for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(posedge clk) #1;
		chk_bit(1'b1, rsp_valid);
		rd = rsp_rdata;
	endtask
	// -------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------
	task automatic t_init;
		for (int n = 0; n < 1000 && init_done !== 1'b1; n++) @(posedge clk);
		#1 chk_bit(1'b1, init_done);
		chk_bit(1'b1, wake >= 8);
	endtask
	// Back-to-back writes to corner cells, then reads of each.
	task automatic t_write_read;
		logic [14:0] addrs [4] = '{15'h0000, 15'h7FFF, 15'h007F, 15'h7F80};
		for (int i = 0; i < 4; i++) access(dmc_pkg::DMC_OP_WRITE, addrs[i], i[0] ^ 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			access(dmc_pkg::DMC_OP_READ, addrs[i], 1'b0);
			chk_bit(i[0] ^ 1'b1, rd);
		end
	endtask
	// Read-modify-write returns the old bit and stores the new one.
	task automatic t_rmw;
		access(dmc_pkg::DMC_OP_WRITE, 15'h1234, 1'b0);
		access(dmc_pkg::DMC_OP_RMW, 15'h1234, 1'b1);
		chk_bit(1'b0, rd);
		access(dmc_pkg::DMC_OP_READ, 15'h1234, 1'b0);
		chk_bit(1'b1, rd);
	endtask
	// Idle long enough for every row to be refreshed; no timing broken.
	task automatic t_refresh;
		repeat (26000) @(posedge clk);
		#1 chk_bit(1'b1, &refreshed);
		chk_cnt(0, viol);
	endtask
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		t_init;
		t_write_read;
		t_rmw;
		t_refresh;
		final_report;
	end
	// Watchdog: the run needs about 27000 cycles.
	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		final_report;
	end
endmodule
bind dmc_ctrl dmc_ctrl_monitor mon (.clk, .nrst, .req_op, .req_ready, .rsp_valid, .init_done,
	.row_strobe_n, .column_strobe_n, .write_strobe_n, .mem_addr);
